// [inc/srs_pkg.sv]
// Constants, register map and types for the step rate and ramp scaler
package srs_pkg;

   // Core clock and the step reference derived from it
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned REF_HZ          = 16_000_000;
   localparam int unsigned REF_GCD         = 4_000_000;
   localparam logic [7:0]  REF_INC         = 8'(REF_HZ / REF_GCD);
   localparam logic [7:0]  REF_MOD         = 8'(CLK_HZ / REF_GCD);

   // Scaling exponents: 2048 * 32 = 2^16, acceleration uses 2^29
   localparam int unsigned VEL_SCALE_EXP   = 16;
   localparam int unsigned ACC_SCALE_EXP   = 29;
   localparam logic [4:0]  STEP_SHIFT_BASE = 5'(VEL_SCALE_EXP);
   localparam logic [4:0]  RAMP_SHIFT_BASE = 5'(ACC_SCALE_EXP - VEL_SCALE_EXP);
   localparam logic signed [5:0] LIM_LO_OFS = 6'sh01;
   localparam logic signed [5:0] LIM_UP_OFS = 6'sh0C;
   localparam logic signed [5:0] LIM_EXP_SAT = 6'sh0B;

   // Value ranges and reset values
   localparam logic [10:0] VEL_MAX         = 11'h7FF;
   localparam logic [10:0] ACC_MAX         = 11'h7FF;
   localparam logic [3:0]  DIV_MAX         = 4'hD;
   localparam logic [3:0]  MRES_MAX        = 4'h8;
   localparam logic [3:0]  MRES_RST        = 4'h8;
   localparam logic [3:0]  PDIV_RST        = 4'h3;
   localparam logic [3:0]  RDIV_RST        = 4'h7;
   localparam logic [10:0] VMAX_RST        = 11'h000;
   localparam logic [10:0] ACC_RST         = 11'h000;

   // Register offsets (byte addresses)
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_VMAX        = 8'h04;
   localparam logic [7:0]  OFS_VTGT        = 8'h08;
   localparam logic [7:0]  OFS_ACCEL       = 8'h0C;
   localparam logic [7:0]  OFS_PDIV        = 8'h10;
   localparam logic [7:0]  OFS_RDIV        = 8'h14;
   localparam logic [7:0]  OFS_MRES        = 8'h18;
   localparam logic [7:0]  OFS_TPOS        = 8'h1C;
   localparam logic [7:0]  OFS_APOS        = 8'h20;
   localparam logic [7:0]  OFS_AVEL        = 8'h24;
   localparam logic [7:0]  OFS_STAT        = 8'h28;
   localparam logic [7:0]  OFS_LIMS        = 8'h2C;

   // Field layouts
   localparam int unsigned STAT_MOVING_BIT = 0;
   localparam int unsigned STAT_REACH_BIT  = 1;
   localparam int unsigned STAT_DIR_BIT    = 2;
   localparam int unsigned LIM_UP_LSB      = 16;

   // Command codes in CTRL[1:0]
   localparam logic [1:0]  CMD_HALT        = 2'h0;
   localparam logic [1:0]  CMD_ROTATE      = 2'h1;
   localparam logic [1:0]  CMD_MOVE        = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_ROTATE = 4'b0010,
      ST_MOVE   = 4'b0100,
      ST_BRAKE  = 4'b1000
   } srs_state_t;

endpackage

// [inc/srs_accum_if.sv]
// Control and carry of one rate accumulator
interface srs_accum_if;
   logic        en;
   logic        clr;
   logic [10:0] inc;
   logic [4:0]  shift;
   logic        pulse;

   modport owner (output en, clr, inc, shift, input pulse);
   modport accum (input en, clr, inc, shift, output pulse);
endinterface

// [core/srs_ref_tick.sv]
// Fractional divider giving a 16 MHz enable pulse from the core clock
module srs_ref_tick
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   output logic      tick_o
);
   import srs_pkg::*;

   typedef struct packed {
      logic [7:0] acc;
      logic       tick;
   } srs_tick_st_t;

   srs_tick_st_t st_ff;
   srs_tick_st_t nxt_st;

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.tick = 1'b0;
      if (st_ff.acc + REF_INC >= REF_MOD)
      begin
         nxt_st.acc  = st_ff.acc + REF_INC - REF_MOD;
         nxt_st.tick = 1'b1;
      end
      else
      begin
         nxt_st.acc = st_ff.acc + REF_INC;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign tick_o = st_ff.tick;
endmodule // srs_ref_tick

// [core/srs_rate_accum.sv]
// Phase accumulator: carries once per 2^shift of summed increments
module srs_rate_accum
(
   input  wire logic  core_clk_i,
   input  wire logic  rst_n_i,
   srs_accum_if.accum acc_if
);
   import srs_pkg::*;

   typedef struct packed {
      logic [29:0] acc;
      logic        pulse;
   } srs_acc_st_t;

   srs_acc_st_t st_ff;
   srs_acc_st_t nxt_st;

   always_comb
   begin
      logic [30:0] sum;
      logic [30:0] lim;
      sum          = {1'b0, st_ff.acc} + 31'(acc_if.inc);
      lim          = 31'h1 << acc_if.shift;
      nxt_st       = st_ff;
      nxt_st.pulse = 1'b0;
      if (acc_if.clr)
      begin
         nxt_st.acc = '0;
      end
      else if (acc_if.en)
      begin
         if (sum >= lim)
         begin
            nxt_st.acc   = 30'(sum - lim);
            nxt_st.pulse = 1'b1;
         end
         else
         begin
            nxt_st.acc = sum[29:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign acc_if.pulse = st_ff.pulse;
endmodule // srs_rate_accum

// [core/srs_step_rate_ramp_scaler.sv]
// Single-axis step pulse generator with velocity and acceleration scaling
module srs_step_rate_ramp_scaler
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  bus_addr_i,
   input  wire logic [31:0] bus_wdata_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   output logic [31:0]      bus_rdata_o,
   output logic             step_o,
   output logic             dir_o,
   output logic             fullstep_o,
   output logic             moving_o
);
   import srs_pkg::*;

   typedef struct packed {
      srs_state_t         st;
      logic [10:0]        vmax;
      logic signed [11:0] vtgt;
      logic [10:0]        accel;
      logic [3:0]         pdiv;
      logic [3:0]         rdiv;
      logic [3:0]         mres;
      logic signed [31:0] tpos;
      logic signed [31:0] pos;
      logic signed [11:0] vel;
      logic [31:0]        ramp_steps;
      logic [7:0]         ustep;
      logic               step;
      logic               dir;
      logic               full;
      logic               moving;
      logic [31:0]        rdata;
   } srs_core_st_t;

   srs_core_st_t st_ff;
   srs_core_st_t nxt_st;

   logic               ref_tick;
   logic [10:0]        vel_abs;
   logic signed [32:0] rem;
   logic [32:0]        rem_abs;
   logic               near;
   logic signed [5:0]  exp_lo;
   logic signed [5:0]  exp_up;
   logic [10:0]        lim_lo;
   logic [10:0]        lim_up;
   logic [10:0]        acc_pos;
   logic [10:0]        acc_use;
   logic signed [11:0] vtgt_lim;
   logic [10:0]        goal_mag;
   logic signed [11:0] goal;
   logic [7:0]         ustep_mask;

   srs_accum_if step_if ();
   srs_accum_if ramp_if ();

   function automatic logic [10:0] sat_u11(input logic [31:0] v, input logic [10:0] mx);
      sat_u11 = (v > 32'(mx)) ? mx : v[10:0];
   endfunction

   function automatic logic [3:0] sat_u4(input logic [31:0] v, input logic [3:0] mx);
      sat_u4 = (v > 32'(mx)) ? mx : v[3:0];
   endfunction

   function automatic logic signed [11:0] sat_s12(input logic signed [31:0] v,
                                                  input logic [10:0] mx);
      if (v > $signed({21'h0, mx}))
         sat_s12 = $signed({1'b0, mx});
      else if (v < -$signed({21'h0, mx}))
         sat_s12 = -$signed({1'b0, mx});
      else
         sat_s12 = v[11:0];
   endfunction

   srs_ref_tick u_ref_tick
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tick_o     (ref_tick)
   );

   srs_rate_accum u_step_accum
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .acc_if     (step_if)
   );

   srs_rate_accum u_ramp_accum
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .acc_if     (ramp_if)
   );

   assign vel_abs = st_ff.vel[11] ? 11'(-st_ff.vel) : st_ff.vel[10:0];
   assign rem     = 33'(st_ff.tpos) - 33'(st_ff.pos);
   assign rem_abs = rem[32] ? 33'(-rem) : 33'(rem);
   assign near    = rem_abs <= {1'b0, st_ff.ramp_steps};

   // Positioning acceleration window from the divisor gap
   assign exp_lo  = $signed({2'b00, st_ff.rdiv}) - $signed({2'b00, st_ff.pdiv}) - LIM_LO_OFS;
   assign exp_up  = $signed({2'b00, st_ff.rdiv}) - $signed({2'b00, st_ff.pdiv}) + LIM_UP_OFS;
   assign lim_lo  = (exp_lo < 0) ? 11'h001 :
                    (exp_lo >= LIM_EXP_SAT) ? ACC_MAX :
                    11'(12'h001 << exp_lo[3:0]);
   assign lim_up  = (exp_up < 0) ? 11'h000 :
                    (exp_up >= LIM_EXP_SAT) ? ACC_MAX :
                    11'((12'h001 << exp_up[3:0]) - 12'h001);
   assign acc_pos = (st_ff.accel < lim_lo) ? ((lim_lo > lim_up) ? lim_up : lim_lo) :
                    (st_ff.accel > lim_up) ? lim_up : st_ff.accel;
   assign acc_use = (st_ff.st == ST_MOVE) ? acc_pos : st_ff.accel;

   // Velocity goal for the ramp per state
   assign vtgt_lim = sat_s12(32'(st_ff.vtgt), st_ff.vmax);
   assign goal_mag = near ? 11'h001 : st_ff.vmax;
   always_comb
   begin
      case (st_ff.st)
         ST_ROTATE: goal = vtgt_lim;
         ST_MOVE:   goal = (rem == 0) ? 12'sh000 :
                           rem[32] ? -$signed({1'b0, goal_mag}) : $signed({1'b0, goal_mag});
         default:   goal = 12'sh000;
      endcase
   end

   // Velocity ramp: one internal unit per 2^(ramp_div+13) summed accelerations
   assign ramp_if.en    = ref_tick && (st_ff.vel != goal);
   assign ramp_if.clr   = (st_ff.vel == goal);
   assign ramp_if.inc   = acc_use;
   assign ramp_if.shift = 5'(st_ff.rdiv) + RAMP_SHIFT_BASE;

   // Step rate: one step per 2^(pulse_div+16) summed velocities at 16 MHz
   assign step_if.en    = ref_tick && (st_ff.vel != 0);
   assign step_if.clr   = (st_ff.vel == 0);
   assign step_if.inc   = vel_abs;
   assign step_if.shift = 5'(st_ff.pdiv) + STEP_SHIFT_BASE;

   assign ustep_mask = 8'((9'h001 << st_ff.mres) - 9'h001);

   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.step  = 1'b0;
      nxt_st.full  = 1'b0;
      nxt_st.rdata = '0;

      // Motion
      if (ramp_if.pulse && (st_ff.vel != goal))
         nxt_st.vel = (goal > st_ff.vel) ? st_ff.vel + 12'sh001 : st_ff.vel - 12'sh001;

      if (step_if.pulse && (st_ff.vel != 0) && !((st_ff.st == ST_MOVE) && (rem == 0)))
      begin
         nxt_st.step  = 1'b1;
         nxt_st.dir   = ~st_ff.vel[11];
         nxt_st.pos   = st_ff.vel[11] ? st_ff.pos - 32'sh1 : st_ff.pos + 32'sh1;
         nxt_st.ustep = st_ff.vel[11] ? st_ff.ustep - 8'h01 : st_ff.ustep + 8'h01;
         nxt_st.full  = ((nxt_st.ustep & ustep_mask) == 8'h00);
         if (st_ff.st == ST_MOVE)
         begin
            if (near)
               nxt_st.ramp_steps = (st_ff.ramp_steps != 0) ? st_ff.ramp_steps - 32'h1 : '0;
            else if (vel_abs < st_ff.vmax)
               nxt_st.ramp_steps = st_ff.ramp_steps + 32'h1;
         end
      end

      case (st_ff.st)
         ST_IDLE:
         begin
            nxt_st.vel = 12'sh000;
         end
         ST_ROTATE:
         begin
            nxt_st.st = ST_ROTATE;
         end
         ST_MOVE:
         begin
            if (rem == 0)
            begin
               nxt_st.vel        = 12'sh000;
               nxt_st.ramp_steps = '0;
               nxt_st.st         = ST_IDLE;
            end
         end
         ST_BRAKE:
         begin
            if (st_ff.vel == 0)
               nxt_st.st = ST_IDLE;
         end
         default:
         begin
            nxt_st.st  = ST_IDLE;
            nxt_st.vel = 12'sh000;
         end
      endcase

      // Register writes
      if (bus_wr_i)
      begin
         case (bus_addr_i)
            OFS_CTRL:
            begin
               case (bus_wdata_i[1:0])
                  CMD_ROTATE: nxt_st.st = ST_ROTATE;
                  CMD_MOVE:
                  begin
                     nxt_st.st         = ST_MOVE;
                     nxt_st.ramp_steps = '0;
                  end
                  default:    nxt_st.st = (st_ff.vel == 0) ? ST_IDLE : ST_BRAKE;
               endcase
            end
            OFS_VMAX:  nxt_st.vmax  = sat_u11(bus_wdata_i, VEL_MAX);
            OFS_VTGT:  nxt_st.vtgt  = sat_s12($signed(bus_wdata_i), VEL_MAX);
            OFS_ACCEL: nxt_st.accel = sat_u11(bus_wdata_i, ACC_MAX);
            OFS_PDIV:  nxt_st.pdiv  = sat_u4(bus_wdata_i, DIV_MAX);
            OFS_RDIV:  nxt_st.rdiv  = sat_u4(bus_wdata_i, DIV_MAX);
            OFS_MRES:  nxt_st.mres  = sat_u4(bus_wdata_i, MRES_MAX);
            OFS_TPOS:  nxt_st.tpos  = $signed(bus_wdata_i);
            OFS_APOS:  nxt_st.pos   = $signed(bus_wdata_i);
            default:   nxt_st.rdata = '0;
         endcase
      end

      // Register reads, data stand one cycle after the strobe
      if (bus_rd_i)
      begin
         case (bus_addr_i)
            OFS_CTRL:  nxt_st.rdata = {28'h0, st_ff.st};
            OFS_VMAX:  nxt_st.rdata = {21'h0, st_ff.vmax};
            OFS_VTGT:  nxt_st.rdata = 32'(st_ff.vtgt);
            OFS_ACCEL: nxt_st.rdata = {21'h0, st_ff.accel};
            OFS_PDIV:  nxt_st.rdata = {28'h0, st_ff.pdiv};
            OFS_RDIV:  nxt_st.rdata = {28'h0, st_ff.rdiv};
            OFS_MRES:  nxt_st.rdata = {28'h0, st_ff.mres};
            OFS_TPOS:  nxt_st.rdata = st_ff.tpos;
            OFS_APOS:  nxt_st.rdata = st_ff.pos;
            OFS_AVEL:  nxt_st.rdata = 32'(st_ff.vel);
            OFS_STAT:
            begin
               nxt_st.rdata[STAT_MOVING_BIT] = st_ff.moving;
               nxt_st.rdata[STAT_REACH_BIT]  = (st_ff.st == ST_IDLE) && (rem == 0);
               nxt_st.rdata[STAT_DIR_BIT]    = st_ff.dir;
            end
            OFS_LIMS:
            begin
               nxt_st.rdata[10:0]                   = lim_lo;
               nxt_st.rdata[LIM_UP_LSB +: 11]       = lim_up;
            end
            default:   nxt_st.rdata = '0;
         endcase
      end

      nxt_st.moving = (nxt_st.st != ST_IDLE) || (nxt_st.vel != 0);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_ff       <= '0;
         st_ff.st    <= ST_IDLE;
         st_ff.vmax  <= VMAX_RST;
         st_ff.accel <= ACC_RST;
         st_ff.pdiv  <= PDIV_RST;
         st_ff.rdiv  <= RDIV_RST;
         st_ff.mres  <= MRES_RST;
         st_ff.dir   <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign bus_rdata_o = st_ff.rdata;
   assign step_o      = st_ff.step;
   assign dir_o       = st_ff.dir;
   assign fullstep_o  = st_ff.full;
   assign moving_o    = st_ff.moving;
endmodule // srs_step_rate_ramp_scaler

// [test/srs_step_rate_ramp_scaler_props.sv]
// Concurrent checks on the ports of the step rate and ramp scaler
module srs_step_rate_ramp_scaler_props
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  bus_addr_i,
   input  wire logic [31:0] bus_wdata_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   input  wire logic [31:0] bus_rdata_o,
   input  wire logic        step_o,
   input  wire logic        dir_o,
   input  wire logic        fullstep_o,
   input  wire logic        moving_o
);
   import srs_pkg::*;

   typedef struct packed {
      logic [3:0] pdiv;
      logic [3:0] rdiv;
      logic [3:0] mres;
   } srs_shadow_t;

   srs_shadow_t sh_ff;
   srs_shadow_t nxt_sh;

   function automatic logic [3:0] sat(logic [31:0] w, logic [3:0] mx);
      return (w > 32'(mx)) ? mx : w[3:0];
   endfunction

   function automatic logic [31:0] lims(logic [3:0] pd, logic [3:0] rd);
      int e;
      int lo;
      int up;
      e = int'(rd) - int'(pd);
      lo = (e < 1) ? 1 : (e > 11) ? 2047 : (1 << (e - 1));
      up = (e < -12) ? 0 : (e > -2) ? 2047 : (1 << (e + 12)) - 1;
      return {5'h00, up[10:0], 5'h00, lo[10:0]};
   endfunction

   // Mirror of the divisor and resolution settings
   always_comb
   begin
      nxt_sh = sh_ff;
      if (bus_wr_i && bus_addr_i == OFS_PDIV)
         nxt_sh.pdiv = sat(bus_wdata_i, DIV_MAX);
      if (bus_wr_i && bus_addr_i == OFS_RDIV)
         nxt_sh.rdiv = sat(bus_wdata_i, DIV_MAX);
      if (bus_wr_i && bus_addr_i == OFS_MRES)
         nxt_sh.mres = sat(bus_wdata_i, MRES_MAX);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sh_ff <= {PDIV_RST, RDIV_RST, MRES_RST};
      else
         sh_ff <= nxt_sh;
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence rd_req(logic [7:0] a);
      bus_rd_i && bus_addr_i == a;
   endsequence

   rdata_idle_a: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   pdiv_read_a: assert property (rd_req(OFS_PDIV) |=> bus_rdata_o == 32'(sh_ff.pdiv))
      else $error("pulse divisor read back wrong");
   mres_read_a: assert property (rd_req(OFS_MRES) |=> bus_rdata_o == 32'(sh_ff.mres))
      else $error("resolution read back wrong");
   lims_read_a: assert property (rd_req(OFS_LIMS) |=>
      bus_rdata_o == lims(sh_ff.pdiv, sh_ff.rdiv)) else $error("accel bounds wrong");
   step_space_a: assert property (step_o |=> !step_o [*5])
      else $error("steps closer than one reference tick");
   full_with_a: assert property (fullstep_o |-> step_o)
      else $error("full step without a microstep");
   full_every_a: assert property (step_o && sh_ff.mres == 4'h0 |-> fullstep_o)
      else $error("full step missing at resolution zero");
   step_moving_a: assert property (step_o |-> moving_o)
      else $error("step while not moving");
   dir_hold_a: assert property ($changed(dir_o) |-> step_o)
      else $error("direction changed without a step");

   full_seen_c: cover property (step_o && fullstep_o);
endmodule // srs_step_rate_ramp_scaler_props

bind srs_step_rate_ramp_scaler srs_step_rate_ramp_scaler_props srs_step_rate_ramp_scaler_props_i
(
   .core_clk_i  (core_clk_i),
   .rst_n_i     (rst_n_i),
   .bus_addr_i  (bus_addr_i),
   .bus_wdata_i (bus_wdata_i),
   .bus_wr_i    (bus_wr_i),
   .bus_rd_i    (bus_rd_i),
   .bus_rdata_o (bus_rdata_o),
   .step_o      (step_o),
   .dir_o       (dir_o),
   .fullstep_o  (fullstep_o),
   .moving_o    (moving_o)
);

// [test/srs_drv_model.sv]
// Motor driver stand-in: tracks position and full steps from the pulses
module srs_drv_model
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic step_i,
   input  wire logic dir_i,
   input  wire logic fullstep_i,
   output int        pos_o,
   output int        full_o
);
   timeunit 1ns;
   timeprecision 100ps;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pos_o <= 0;
         full_o <= 0;
      end
      else if (step_i === 1'b1)
      begin
         pos_o <= (dir_i === 1'b1) ? pos_o + 1 : pos_o - 1;
         full_o <= full_o + int'(fullstep_i);
      end
   end
endmodule // srs_drv_model

// [test/srs_step_rate_ramp_scaler_test.sv]
// Register and step-rate bench for the step rate and ramp scaler
module srs_step_rate_ramp_scaler_test;
   timeunit 1ns;
   timeprecision 100ps;
   import srs_pkg::*;

   logic        clk;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic        step;
   logic        dir;
   logic        full;
   logic        mov;
   logic [7:0]  addr;
   logic [31:0] wd;
   logic [31:0] rdat;
   logic [31:0] d;
   int          failures;
   int          n_checks;
   int          pos;
   int          fulls;
   int          p0;
   int          f0;
   int          i;
   time         t0;
   logic [4:0]  tp [6] = '{5'h03, 5'h07, 5'h14, 5'h00, 5'h05, 5'h0A};
   logic [4:0]  tr [6] = '{5'h07, 5'h03, 5'h00, 5'h14, 5'h05, 5'h00};
   logic [31:0] tl [6] = '{32'h07FF_0008, 32'h00FF_0001, 32'h0000_0001,
                           32'h07FF_07FF, 32'h07FF_0001, 32'h0003_0001};

   srs_step_rate_ramp_scaler srs_step_rate_ramp_scaler_i
   (
      .core_clk_i  (clk),
      .rst_n_i     (rst_n),
      .bus_addr_i  (addr),
      .bus_wdata_i (wd),
      .bus_wr_i    (wr),
      .bus_rd_i    (rd),
      .bus_rdata_o (rdat),
      .step_o      (step),
      .dir_o       (dir),
      .fullstep_o  (full),
      .moving_o    (mov)
   );

   srs_drv_model srs_drv_model_i
   (
      .core_clk_i (clk),
      .rst_n_i    (rst_n),
      .step_i     (step),
      .dir_i      (dir),
      .fullstep_i (full),
      .pos_o      (pos),
      .full_o     (fulls)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdat;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a, d);
      chk(d, e);
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Polls actual velocity; a stuck ramp ends the run
   task automatic wait_vel(input logic [11:0] v, input int lim);
      for (i = 0; i < lim; i += 3)
      begin
         rd_reg(OFS_AVEL, d);
         if (d[11:0] === v)
            break;
      end
      if (i >= lim)
      begin
         failures++;
         $display("wrong value at %0t: velocity never settled", $time);
         end_of_test();
      end
   endtask

   initial
   begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wd = 32'h0;
      rst_n = 1'b0;
      failures = 0;
      n_checks = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rchk(OFS_MRES, 32'h8);
      rchk(OFS_PDIV, 32'h3);
      wr_reg(8'h30, 32'hFFFF_FFFF);
      rchk(8'h30, 32'h0);
      wr_reg(OFS_AVEL, 32'h55);
      rchk(OFS_AVEL, 32'h0);
      wr_reg(OFS_VMAX, 32'hFFF);
      rchk(OFS_VMAX, 32'h7FF);
      wr_reg(OFS_VTGT, 32'h800);
      rchk(OFS_VTGT, 32'h7FF);
      wr_reg(OFS_ACCEL, 32'h1000);
      rchk(OFS_ACCEL, 32'h7FF);
      wr_reg(OFS_MRES, 32'h9);
      rchk(OFS_MRES, 32'h8);
      for (int k = 0; k < 6; k++)
      begin
         wr_reg(OFS_PDIV, 32'(tp[k]));
         wr_reg(OFS_RDIV, 32'(tr[k]));
         rchk(OFS_LIMS, tl[k]);
      end
      $display("register test done");
      // Divider gap caps positioning at 511, rotation keeps full accel
      wr_reg(OFS_PDIV, 32'h3);
      wr_reg(OFS_RDIV, 32'h0);
      wr_reg(OFS_MRES, 32'h0);
      wr_reg(OFS_VTGT, 32'h200);
      wr_reg(OFS_CTRL, 32'h1);
      t0 = $time;
      wait_vel(12'h200, 20000);
      chk(32'(($time - t0) / 10 inside {[12000:13600]}), 32'h1);
      rchk(OFS_CTRL, 32'h2);
      p0 = pos;
      f0 = fulls;
      repeat (25600) @(posedge clk);
      chk(32'(pos - p0 inside {[3:5]}), 32'h1);
      chk(32'(fulls - f0), 32'(pos - p0));
      chk(32'(dir), 32'h1);
      $display("rotate test done");
      wr_reg(OFS_VTGT, 32'hFFFF_FE00);
      wait_vel(12'hE00, 40000);
      p0 = pos;
      repeat (12800) @(posedge clk);
      chk(32'(pos < p0), 32'h1);
      chk(32'(dir), 32'h0);
      $display("reverse test done");
      wr_reg(OFS_CTRL, 32'h0);
      for (i = 0; i < 20000; i++)
      begin
         @(negedge clk);
         if (mov === 1'b0)
            break;
      end
      chk(32'(i < 20000), 32'h1);
      rchk(OFS_CTRL, 32'h1);
      p0 = pos;
      repeat (1000) @(posedge clk);
      chk(32'(pos), 32'(p0));
      $display("halt test done");
      // One-step move: positioning accel capped at 1023, first step after ~2050 ticks
      wr_reg(OFS_PDIV, 32'h2);
      rchk(OFS_LIMS, 32'h03FF_0001);
      wr_reg(OFS_APOS, 32'h0);
      wr_reg(OFS_TPOS, 32'h1);
      p0 = pos;
      wr_reg(OFS_CTRL, 32'h2);
      t0 = $time;
      for (i = 0; i < 20000; i++)
      begin
         @(negedge clk);
         if (mov === 1'b0)
            break;
      end
      chk(32'(i < 20000), 32'h1);
      chk(32'(($time - t0) / 10 inside {[12000:13600]}), 32'h1);
      chk(32'(pos - p0), 32'h1);
      rchk(OFS_STAT, 32'h6);
      rchk(OFS_APOS, 32'h1);
      $display("move test done");
      end_of_test();
   end
endmodule // srs_step_rate_ramp_scaler_test
